// ===== core/qbp_params.svh
// Holds the timing and reset constants of the quasi-bidirectional port block.
// Assumes it is included by bare name from the design files only.
`ifndef QBP_PARAMS_SVH
`define QBP_PARAMS_SVH

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define QBP_PORT_WIDTH      8
`define QBP_P4_WIDTH        2
`define QBP_LATCH_RESET     8'hFF
`define QBP_P4_RESET        2'h3

// ****************************************************************
// Timing: states per machine cycle, phases per state
// ****************************************************************
`define QBP_STATES_PER_CYCLE 6
`define QBP_PHASES_PER_STATE 2
`define QBP_BOOST_PERIODS    2

`endif

// ===== core/qbp_pkg.sv
// Holds the types shared by the port block files.
// Assumes the params header sits beside it in core/.
`include "qbp_params.svh"

package qbp_pkg;

  // ****************************************************************
  // Port personality
  // ****************************************************************
  typedef enum logic [1:0] {
    QBP_KIND_BUS0,   // Port zero: open drain, address/data bus
    QBP_KIND_BUS2,   // Port two: quasi-bidir, high address byte
    QBP_KIND_ALT     // Ports one, three, four: alternate functions
  } qbp_kind_t;

  // ****************************************************************
  // Timing generator states
  // ****************************************************************
  typedef enum logic [1:0] {
    QBP_TG_IDLE,     // Outside the boost window
    QBP_TG_PH1,      // State 1 phase 2
    QBP_TG_PH2       // State 2 phase 1
  } qbp_tg_state_t;

endpackage

// ===== core/qbp_bit_slice.sv
// Holds one port of latches plus the per-bit pad control decode.
// Assumes the CPU strobes are synchronous to ref_clk_i and one cycle long.
`include "qbp_params.svh"

module qbp_bit_slice
  import qbp_pkg::*;
#(
  parameter int        WIDTH = `QBP_PORT_WIDTH,
  parameter qbp_kind_t KIND  = QBP_KIND_ALT
) (
  input  wire logic             ref_clk_i,        // Phase clock
  input  wire logic             reset_n_i,        // Sync reset, active low
  input  wire logic             write_latch_i,    // Write-to-latch strobe
  input  wire logic [WIDTH-1:0] bus_data_i,       // Internal bus value
  input  wire logic             phase1_i,         // Phase 1 of any state
  input  wire logic             state1_phase1_i,  // State 1 phase 1 marker
  input  wire logic             boost_i,          // State 1 phase 2 or state 2 phase 1
  input  wire logic             ext_bus_i,        // Drivers on external bus
  input  wire logic             addr16_i,         // 16-bit address in use
  input  wire logic [WIDTH-1:0] ext_data_i,       // Bus value to emit
  input  wire logic [WIDTH-1:0] alt_out_i,        // Alternate output values
  output logic      [WIDTH-1:0] latch_o,          // Stored latch
  output logic      [WIDTH-1:0] strong_pulldown_o, // Pulldown enable
  output logic      [WIDTH-1:0] weak_pullup_o,    // Weak pullup enable
  output logic      [WIDTH-1:0] boost_pullup_o    // Strong pullup enable
);

  logic [WIDTH-1:0] driven;     // Value the output buffer holds
  logic [WIDTH-1:0] rise;       // Zero-to-one seen at buffer update
  logic [WIDTH-1:0] level;      // Effective level toward the pad

  // ****************************************************************
  // Latch: held during external bus use, untouched by it
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      latch_o <= WIDTH'(`QBP_LATCH_RESET);
    end else if (write_latch_i) begin
      latch_o <= bus_data_i;
    end
  end

  // ****************************************************************
  // Output buffer samples the latch only at state 1 phase 1
  // ****************************************************************
  // Sampling once per cycle keeps a mid-cycle write off the pin.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      driven <= WIDTH'(`QBP_LATCH_RESET);
      rise   <= '0;
    end else if (state1_phase1_i && phase1_i) begin
      driven <= latch_o;
      rise   <= latch_o & ~driven;
    end else if (!boost_i) begin
      rise   <= '0;
    end
  end

  // ****************************************************************
  // Pad control decode per bit
  // ****************************************************************
  always_comb begin
    level = driven;
    if (KIND == QBP_KIND_ALT) begin
      level = driven & alt_out_i;
    end
    strong_pulldown_o = '0;
    weak_pullup_o     = '0;
    boost_pullup_o    = '0;
    if (ext_bus_i && KIND != QBP_KIND_ALT &&
        (KIND == QBP_KIND_BUS0 || addr16_i)) begin
      // Latch cut off; emit bus value with strong pullups
      strong_pulldown_o = ~ext_data_i;
      boost_pullup_o    = ext_data_i;
    end else if (KIND == QBP_KIND_BUS0) begin
      // Open drain: a one floats the pin
      strong_pulldown_o = ~level;
    end else begin
      strong_pulldown_o = ~level;
      weak_pullup_o     = level;
      boost_pullup_o    = rise & level & {WIDTH{boost_i}};
    end
  end

endmodule

// ===== core/qbp_port_top.sv
// Holds the five-port quasi-bidirectional I/O block with read muxing.
// Assumes the CPU gives one-cycle strobes and a port select; pins arrive
// already synchronous to ref_clk_i; analog pad drivers live outside.
`include "qbp_params.svh"

module qbp_port_top
  import qbp_pkg::*;
#(
  parameter int W  = `QBP_PORT_WIDTH,
  parameter int W4 = `QBP_P4_WIDTH
) (
  input  wire logic          ref_clk_i,          // 50 MHz phase clock
  input  wire logic          reset_n_i,          // Sync reset, active low
  input  wire logic [2:0]    port_sel_i,         // Port addressed, 0..4
  input  wire logic          write_latch_i,      // Write-to-latch strobe
  input  wire logic          read_latch_i,       // Read-latch strobe
  input  wire logic          read_pin_i,         // Read-pin strobe
  input  wire logic [W-1:0]  bus_data_i,         // Internal bus write data
  output logic      [W-1:0]  bus_data_o,         // Internal bus read data
  output logic               bus_valid_o,        // Read data valid
  input  wire logic          external_access_select_i, // Ext-access pin level
  input  wire logic          pc_external_i,      // Program counter off-chip
  input  wire logic          ext_cycle_i,        // External memory cycle now
  input  wire logic          addr16_i,           // 16-bit address in use
  input  wire logic [W-1:0]  addr_data_lo_i,     // Low address / data byte
  input  wire logic [W-1:0]  addr_hi_i,          // High address byte
  input  wire logic          ext_store_n_i,      // Ext data store strobe
  input  wire logic          ext_load_n_i,       // Ext data load strobe
  input  wire logic [W-1:0]  alt1_out_i,         // Port one alternate outputs
  input  wire logic [W-1:0]  alt3_out_i,         // Port three alternate outputs
  input  wire logic [W4-1:0] alt4_out_i,         // Port four alternate outputs
  input  wire logic [W-1:0]  pin0_i,             // Port zero pin levels
  input  wire logic [W-1:0]  pin1_i,             // Port one pin levels
  input  wire logic [W-1:0]  pin2_i,             // Port two pin levels
  input  wire logic [W-1:0]  pin3_i,             // Port three pin levels
  input  wire logic [W4-1:0] pin4_i,             // Port four pin levels
  output logic      [W-1:0]  alt1_in_o,          // Port one alternate inputs
  output logic      [W-1:0]  alt3_in_o,          // Port three alternate inputs
  output logic      [W4-1:0] alt4_in_o,          // Port four alternate inputs
  output logic               ext_bus_o,          // Ports zero/two on bus
  output logic      [5*W-1:0] strong_pulldown_o, // Pulldown enables, 8 per port
  output logic      [5*W-1:0] weak_pullup_o,     // Weak pullup enables
  output logic      [5*W-1:0] boost_pullup_o     // Strong pullup enables
);

  // ****************************************************************
  // Machine cycle timing
  // ****************************************************************
  localparam int PHASES = `QBP_STATES_PER_CYCLE * `QBP_PHASES_PER_STATE;
  // Counter starts at zero after reset
  // so the first edge updates buffers

  logic [3:0]    phase_cnt;     // Oscillator period within machine cycle
  qbp_tg_state_t tg_state;      // Boost window tracker
  logic          phase1;        // Phase 1 of current state
  logic          state1_phase1; // State 1 phase 1
  logic          boost_win;     // State 1 phase 2 and state 2 phase 1

  // Free-running counter: one tick per oscillator period
  // It never pauses for bus activity
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      phase_cnt <= '0;
    end else if (phase_cnt == 4'(PHASES - 1)) begin
      phase_cnt <= '0;
    end else begin
      phase_cnt <= phase_cnt + 4'h1;
    end
  end

  // Odd counts are phase 2
  assign phase1        = ~phase_cnt[0];
  assign state1_phase1 = (phase_cnt == 4'h0);

  // Window covers exactly the two periods after state 1 phase 1
  // Opening on the buffer update edge keeps
  // a fresh rise on for two full edges
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tg_state <= QBP_TG_IDLE;
    end else begin
      unique case (tg_state)
        QBP_TG_IDLE: begin
          if (state1_phase1 && phase1) begin
            tg_state <= QBP_TG_PH1;
          end
        end
        QBP_TG_PH1: begin
          tg_state <= QBP_TG_PH2;
        end
        QBP_TG_PH2: begin
          tg_state <= QBP_TG_IDLE;
        end
        default: begin
          tg_state <= QBP_TG_IDLE;                          // Stray code
        end
      endcase
    end
  end

  // Buffer update happens on the state1_phase1 edge, so the window follows it
  assign boost_win = (tg_state != QBP_TG_IDLE);

  // ****************************************************************
  // External bus handover
  // ****************************************************************
  // Either an off-chip program counter or a forced external fetch
  // hands the drivers over; only during real cycles to keep I/O free.
  // The select pin is active low
  assign ext_bus_o = ext_cycle_i &
                     (pc_external_i | ~external_access_select_i);

  // ****************************************************************
  // Port instances
  // ****************************************************************
  // Latch copies for reads and alt gates
  logic [W-1:0]  latch0, latch1, latch2, latch3;  // Latch contents
  logic [W-1:0]  latch4_full;                      // Port four, padded
  logic [W-1:0]  alt3_eff;                         // Port three alt outputs
  logic [W-1:0]  wr_sel;                           // One-hot write select
  logic [W-1:0]  alt4_full;                        // Port four alt, padded

  // Store/load strobes ride on port three bits six and seven
  always_comb begin
    alt3_eff    = alt3_out_i;
    alt3_eff[6] = alt3_out_i[6] & ext_store_n_i;
    alt3_eff[7] = alt3_out_i[7] & ext_load_n_i;
    alt4_full   = {{(W-W4){1'b1}}, alt4_out_i};
  end

  // Selects 5..7 write nothing
  genvar gp;
  generate
    for (gp = 0; gp < 5; gp++) begin : g_sel
      assign wr_sel[gp] = write_latch_i && (port_sel_i == 3'(gp));
    end
    for (gp = 5; gp < W; gp++) begin : g_unused
      assign wr_sel[gp] = 1'b0;
    end
  endgenerate

  // Port zero: open drain unless on bus
  qbp_bit_slice #(.WIDTH(W), .KIND(QBP_KIND_BUS0)) u_port0 (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .write_latch_i     (wr_sel[0]),
    .bus_data_i        (bus_data_i),
    .phase1_i          (phase1),
    .state1_phase1_i   (state1_phase1),
    .boost_i           (boost_win),
    .ext_bus_i         (ext_bus_o),
    .addr16_i          (addr16_i),
    .ext_data_i        (addr_data_lo_i),
    .alt_out_i         ({W{1'b1}}),
    .latch_o           (latch0),
    .strong_pulldown_o (strong_pulldown_o[0*W +: W]),
    .weak_pullup_o     (weak_pullup_o[0*W +: W]),
    .boost_pullup_o    (boost_pullup_o[0*W +: W])
  );

  // Port one: alternate outputs
  qbp_bit_slice #(.WIDTH(W), .KIND(QBP_KIND_ALT)) u_port1 (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .write_latch_i     (wr_sel[1]),
    .bus_data_i        (bus_data_i),
    .phase1_i          (phase1),
    .state1_phase1_i   (state1_phase1),
    .boost_i           (boost_win),
    .ext_bus_i         (1'b0),
    .addr16_i          (1'b0),
    .ext_data_i        ({W{1'b1}}),
    .alt_out_i         (alt1_out_i),
    .latch_o           (latch1),
    .strong_pulldown_o (strong_pulldown_o[1*W +: W]),
    .weak_pullup_o     (weak_pullup_o[1*W +: W]),
    .boost_pullup_o    (boost_pullup_o[1*W +: W])
  );

  // Port two: on bus with long addresses
  qbp_bit_slice #(.WIDTH(W), .KIND(QBP_KIND_BUS2)) u_port2 (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .write_latch_i     (wr_sel[2]),
    .bus_data_i        (bus_data_i),
    .phase1_i          (phase1),
    .state1_phase1_i   (state1_phase1),
    .boost_i           (boost_win),
    .ext_bus_i         (ext_bus_o),
    .addr16_i          (addr16_i),
    .ext_data_i        (addr_hi_i),
    .alt_out_i         ({W{1'b1}}),
    .latch_o           (latch2),
    .strong_pulldown_o (strong_pulldown_o[2*W +: W]),
    .weak_pullup_o     (weak_pullup_o[2*W +: W]),
    .boost_pullup_o    (boost_pullup_o[2*W +: W])
  );

  // Port three: strobes merged already
  qbp_bit_slice #(.WIDTH(W), .KIND(QBP_KIND_ALT)) u_port3 (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .write_latch_i     (wr_sel[3]),
    .bus_data_i        (bus_data_i),
    .phase1_i          (phase1),
    .state1_phase1_i   (state1_phase1),
    .boost_i           (boost_win),
    .ext_bus_i         (1'b0),
    .addr16_i          (1'b0),
    .ext_data_i        ({W{1'b1}}),
    .alt_out_i         (alt3_eff),
    .latch_o           (latch3),
    .strong_pulldown_o (strong_pulldown_o[3*W +: W]),
    .weak_pullup_o     (weak_pullup_o[3*W +: W]),
    .boost_pullup_o    (boost_pullup_o[3*W +: W])
  );

  // Port four keeps full width internally; upper bits are tied off
  // in the pad ring, the bus only ever sees the low bits.
  qbp_bit_slice #(.WIDTH(W), .KIND(QBP_KIND_ALT)) u_port4 (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .write_latch_i     (wr_sel[4]),
    .bus_data_i        ({{(W-W4){1'b1}}, bus_data_i[W4-1:0]}),
    .phase1_i          (phase1),
    .state1_phase1_i   (state1_phase1),
    .boost_i           (boost_win),
    .ext_bus_i         (1'b0),
    .addr16_i          (1'b0),
    .ext_data_i        ({W{1'b1}}),
    .alt_out_i         (alt4_full),
    .latch_o           (latch4_full),
    .strong_pulldown_o (strong_pulldown_o[4*W +: W]),
    .weak_pullup_o     (weak_pullup_o[4*W +: W]),
    .boost_pullup_o    (boost_pullup_o[4*W +: W])
  );

  // ****************************************************************
  // Alternate inputs: gated by the latch
  // ****************************************************************
  // A zero latch holds the pin low, so the peripheral sees zero.
  // Port four gates its W4 pins only
  always_comb begin
    alt1_in_o = pin1_i & latch1;
    alt3_in_o = pin3_i & latch3;
    alt4_in_o = pin4_i & latch4_full[W4-1:0];
  end

  // ****************************************************************
  // Read path: latch or pin, same port address
  // ****************************************************************
  // Read-modify-write sequences use the latch strobe so a loaded pin
  // cannot corrupt bits the instruction did not mean to change.
  // Unmapped selects read as zero
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      bus_data_o  <= '0;
      bus_valid_o <= 1'b0;
    end else begin
      bus_valid_o <= read_latch_i | read_pin_i;
      if (read_latch_i) begin
        unique case (port_sel_i)
          3'h0:    bus_data_o <= latch0;
          3'h1:    bus_data_o <= latch1;
          3'h2:    bus_data_o <= latch2;
          3'h3:    bus_data_o <= latch3;
          3'h4:    bus_data_o <= {{(W-W4){1'b0}}, latch4_full[W4-1:0]};
          default: bus_data_o <= '0;
        endcase
      end else if (read_pin_i) begin
        unique case (port_sel_i)
          3'h0:    bus_data_o <= pin0_i;
          3'h1:    bus_data_o <= pin1_i;
          3'h2:    bus_data_o <= pin2_i;
          3'h3:    bus_data_o <= pin3_i;
          3'h4:    bus_data_o <= {{(W-W4){1'b0}}, pin4_i};
          default: bus_data_o <= '0;
        endcase
      end
    end
  end

endmodule

// ===== bench/qbp_port_monitor.sv
// Concurrent checks on the quasi-bidirectional port block top.
// Assumes one clock domain and a synchronous active-low reset.
// ****************************************************************
// Checker
// ****************************************************************
module qbp_port_monitor #(
  parameter int W  = 8,
  parameter int W4 = 2
) (
  input wire logic           ref_clk_i,                // Clock
  input wire logic           reset_n_i,                // Reset, active low
  input wire logic [2:0]     port_sel_i,               // Port select
  input wire logic           read_latch_i,             // Latch read strobe
  input wire logic           read_pin_i,               // Pin read strobe
  input wire logic [W-1:0]   bus_data_o,               // Read data
  input wire logic           bus_valid_o,              // Read data valid
  input wire logic           external_access_select_i, // Ext-access level
  input wire logic           pc_external_i,            // PC off-chip
  input wire logic           ext_cycle_i,              // External cycle
  input wire logic [W-1:0]   pin1_i,                   // Port one pins
  input wire logic [W-1:0]   pin3_i,                   // Port three pins
  input wire logic [W-1:0]   alt1_in_o,                // Port one alt inputs
  input wire logic [W-1:0]   alt3_in_o,                // Port three alt inputs
  input wire logic           ext_bus_o,                // Bus handover
  input wire logic [5*W-1:0] strong_pulldown_o,        // Pulldown enables
  input wire logic [5*W-1:0] weak_pullup_o,            // Weak pullup enables
  input wire logic [5*W-1:0] boost_pullup_o            // Boost enables
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every check belongs to the one clock and is muted during reset
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_valid_after_read: assert property ((read_latch_i || read_pin_i) |=> bus_valid_o)
    else $error("no valid after read");
  a_valid_one_shot: assert property (!(read_latch_i || read_pin_i) |=> !bus_valid_o)
    else $error("valid without read");
  a_pin_read_data: assert property (read_pin_i && !read_latch_i && port_sel_i == 3'h1
    |=> bus_data_o == $past(pin1_i))
    else $error("pin read data wrong");
  a_unmapped_read_zero: assert property ((read_latch_i || read_pin_i) && port_sel_i > 3'h4
    |=> bus_data_o == '0)
    else $error("unmapped read not zero");
  a_bus_select_eq: assert property (ext_bus_o ==
    (ext_cycle_i && (pc_external_i || !external_access_select_i)))
    else $error("bus select wrong");
  a_port0_no_weak: assert property (weak_pullup_o[W-1:0] == '0)
    else $error("port zero weak pullup on");
  // Boost must last exactly two periods, the hazard is a stuck pullup
  a_boost_two_cycles: assert property ($rose(boost_pullup_o[W])
    |=> boost_pullup_o[W] ##1 !boost_pullup_o[W])
    else $error("boost length wrong");
  a_alt_in_gated: assert property (((alt1_in_o & ~pin1_i) == '0)
    && ((alt3_in_o & ~pin3_i) == '0))
    else $error("alt input not gated");
  a_reset_all_ones: assert property ($rose(reset_n_i)
    |-> strong_pulldown_o == '0 && (&weak_pullup_o[5*W-1:W]))
    else $error("reset state wrong");
endmodule

bind qbp_port_top qbp_port_monitor #(.W(W), .W4(W4)) u_mon (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .port_sel_i(port_sel_i),
  .read_latch_i(read_latch_i), .read_pin_i(read_pin_i), .bus_data_o(bus_data_o),
  .bus_valid_o(bus_valid_o), .external_access_select_i(external_access_select_i),
  .pc_external_i(pc_external_i), .ext_cycle_i(ext_cycle_i), .pin1_i(pin1_i),
  .pin3_i(pin3_i), .alt1_in_o(alt1_in_o), .alt3_in_o(alt3_in_o), .ext_bus_o(ext_bus_o),
  .strong_pulldown_o(strong_pulldown_o), .weak_pullup_o(weak_pullup_o),
  .boost_pullup_o(boost_pullup_o));

// ===== bench/qbp_pin_model.sv
// Pads plus outside circuitry: turns pad enables into pin levels.
// Assumes the bench only drives a pin where the latch holds one.
module qbp_pin_model #(
  parameter int N = 40
) (
  input  wire logic         clk_i,     // Clock
  input  wire logic [N-1:0] pd_i,      // Pulldown enables
  input  wire logic [N-1:0] wp_i,      // Weak pullup enables
  input  wire logic [N-1:0] bp_i,      // Boost pullup enables
  input  wire logic [N-1:0] ext_en_i,  // Outside source drives
  input  wire logic [N-1:0] ext_val_i, // Outside source level
  output logic      [N-1:0] pin_o      // Pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] float_q = '0;  // Undriven pins wander each cycle
  logic [N-1:0] up;            // Any pullup on
  // A floating pin must not look like a held value
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  // Pulldown beats everything, an outside source beats pullups
  always_comb begin
    up    = wp_i | bp_i;
    pin_o = ~pd_i & ((ext_en_i & ext_val_i) | (~ext_en_i & (up | float_q)));
  end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the port block with a pin model.
// Assumes pad enables settle within one machine cycle of a write.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, wr = 0, rl = 0, rp = 0;
  logic [2:0]  sel = 0;
  logic [7:0]  wd = 0, rdata, alo = 0, ahi = 0, alt1 = 8'hFF, alt3 = 8'hFF;
  logic        eas = 1, pcx = 0, cyc = 0, a16 = 0, st_n = 1, ld_n = 1, rv, ebus;
  logic [39:0] pins, pd, wp, bp, xen = 0, xval = 0;
  logic [7:0]  a1in, a3in, d;
  logic [1:0]  a4in;
  int          n_mismatch = 0, checks = 0, n;
  always #10 clk = ~clk;
  qbp_port_top u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .port_sel_i(sel),
    .write_latch_i(wr), .read_latch_i(rl), .read_pin_i(rp), .bus_data_i(wd),
    .bus_data_o(rdata), .bus_valid_o(rv), .external_access_select_i(eas),
    .pc_external_i(pcx), .ext_cycle_i(cyc), .addr16_i(a16), .addr_data_lo_i(alo),
    .addr_hi_i(ahi), .ext_store_n_i(st_n), .ext_load_n_i(ld_n), .alt1_out_i(alt1),
    .alt3_out_i(alt3), .alt4_out_i(2'h3), .pin0_i(pins[7:0]), .pin1_i(pins[15:8]),
    .pin2_i(pins[23:16]), .pin3_i(pins[31:24]), .pin4_i(pins[33:32]),
    .alt1_in_o(a1in), .alt3_in_o(a3in), .alt4_in_o(a4in), .ext_bus_o(ebus),
    .strong_pulldown_o(pd), .weak_pullup_o(wp), .boost_pullup_o(bp));
  qbp_pin_model u_pins (.clk_i(clk), .pd_i(pd), .wp_i(wp), .bp_i(bp),
    .ext_en_i(xen), .ext_val_i(xval), .pin_o(pins));
  // ****************************************************************
  // Bus cycles and compares
  // ****************************************************************
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_port(input logic [2:0] p, input logic [7:0] v);
    @(negedge clk); sel = p; wd = v; wr = 1;
    @(negedge clk); wr = 0;
  endtask
  // Latch read when lat is set, pin read otherwise
  task automatic rd_port(input logic [2:0] p, input bit lat, output logic [7:0] v);
    @(negedge clk); sel = p; rl = lat; rp = !lat;
    @(negedge clk); rl = 0; rp = 0;
    cmp(rv, 1, "valid");
    v = rdata;
  endtask
  // Polls one port's pads for up to 16 clocks, then compares masked fields
  task automatic pads(input int p, input bit [2:0] m, input logic [7:0] epd,
                      input logic [7:0] ewp, input logic [7:0] ebp);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if ((!m[0] || pd[p*8+:8] === epd) && (!m[1] || wp[p*8+:8] === ewp)
          && (!m[2] || bp[p*8+:8] === ebp)) break;
    end
    if (m[0]) cmp(pd[p*8+:8], epd, "pulldown");
    if (m[1]) cmp(wp[p*8+:8], ewp, "weak pullup");
    if (m[2]) cmp(bp[p*8+:8], ebp, "boost");
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    cmp(pd, 40'h00_0000_0000, "reset pd");
    cmp(wp, 40'hFF_FFFF_FF00, "reset wp");
    cmp(bp, 40'h00_0000_0000, "reset bp");
    cmp({a1in, a4in}, {8'hFF, 2'h3}, "alt inputs");
    for (int p = 0; p < 5; p++) begin
      rd_port(p[2:0], 1, d);
      cmp(d & (p == 4 ? 8'h03 : 8'hFF), p == 4 ? 8'h03 : 8'hFF, "reset latch");
    end
    $display("test reset done");
  endtask
  task automatic t_latch_pin;
    wr_port(1, 8'h5A);
    rd_port(1, 1, d); cmp(d, 8'h5A, "latch");
    pads(1, 3'b011, 8'hA5, 8'h5A, 8'h00);
    rd_port(1, 0, d); cmp(d, 8'h5A, "pin");
    xen[9] = 1;
    rd_port(1, 0, d); cmp(d, 8'h58, "pin pulled low");
    rd_port(1, 1, d); cmp(d, 8'h5A, "latch not pin");
    wr_port(1, d | 8'h80);
    rd_port(1, 1, d); cmp(d, 8'hDA, "modify write");
    xen[9] = 0;
    $display("test latch_pin done");
  endtask
  task automatic t_boost;
    wr_port(1, 8'h00);
    pads(1, 3'b011, 8'hFF, 8'h00, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr_port(1, 8'hFF);
      n = 0;
      repeat (16) begin
        @(negedge clk);
        if (bp[15:8] === 8'hFF) n++;
      end
      cmp(n, k == 0 ? 2 : 0, "boost cycles");
    end
    pads(1, 3'b111, 8'h00, 8'hFF, 8'h00);
    $display("test boost done");
  endtask
  task automatic t_port0;
    wr_port(0, 8'h00);
    pads(0, 3'b111, 8'hFF, 8'h00, 8'h00);
    wr_port(0, 8'hFF);
    pads(0, 3'b111, 8'h00, 8'h00, 8'h00);
    $display("test port0 done");
  endtask
  task automatic t_bus;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk); {cyc, pcx, eas} = i[2:0];
      #1 cmp(ebus, cyc & (pcx | ~eas), "bus select");
    end
    wr_port(2, 8'h00);
    alo = 8'hA5; ahi = 8'h3C; a16 = 1; cyc = 1; pcx = 1; eas = 1;
    pads(0, 3'b111, 8'h5A, 8'h00, 8'hA5);
    pads(2, 3'b111, 8'hC3, 8'h00, 8'h3C);
    rd_port(2, 1, d); cmp(d, 8'h00, "latch kept");
    a16 = 0;
    pads(2, 3'b111, 8'hFF, 8'h00, 8'h00);
    cyc = 0;
    pads(0, 3'b111, 8'h00, 8'h00, 8'h00);
    wr_port(2, 8'hFF);
    $display("test bus done");
  endtask
  task automatic t_alt;
    st_n = 0;
    pads(3, 3'b001, 8'h40, 8'h00, 8'h00);
    st_n = 1; ld_n = 0;
    pads(3, 3'b001, 8'h80, 8'h00, 8'h00);
    ld_n = 1; alt1 = 8'hFE;
    pads(1, 3'b001, 8'h01, 8'h00, 8'h00);
    alt1 = 8'hFF;
    wr_port(3, 8'hF0); xen[28] = 1;
    pads(3, 3'b001, 8'h0F, 8'h00, 8'h00);
    cmp(a3in, 8'hE0, "alt input");
    xen[28] = 0;
    wr_port(3, 8'hFF);
    wr_port(4, 8'h00);
    pads(4, 3'b001, 8'h03, 8'h00, 8'h00);
    wr_port(4, 8'hFF);
    $display("test alt done");
  endtask
  task automatic t_unmapped;
    wr_port(5, 8'h00);
    repeat (14) @(negedge clk);
    cmp(pd, 40'h00_0000_0000, "unmapped write");
    rd_port(6, 1, d); cmp(d, 8'h00, "unmapped latch");
    rd_port(7, 0, d); cmp(d, 8'h00, "unmapped pin");
    wr_port(2, 8'h00);
    @(negedge clk); rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    pads(2, 3'b011, 8'h00, 8'hFF, 8'h00);
    rd_port(2, 1, d); cmp(d, 8'hFF, "reset latch");
    $display("test unmapped_reset done");
  endtask
  // ****************************************************************
  // Verdict, sequence and watchdog
  // ****************************************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_reset; t_latch_pin; t_boost; t_port0; t_bus; t_alt; t_unmapped;
    close_out;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #(20 * 5000);
    n_mismatch++;
    close_out;
  end
endmodule
